/* File: hdl/orb_pkg.sv */
// constants, types and decode helpers of the offload register router
// assumes one clock domain shared by host port, router and offload cores
package orb_pkg;

  // port widths
  localparam int ADDR_W = 16;
  localparam int HOST_W = 64;
  localparam int REG_W = 32;
  localparam int LOCAL_W = 9;
  localparam int IDX_W = 5;
  localparam int BANKS = 2;

  // bank windows on the host address
  localparam logic [ADDR_W-1:0] BANK0_LAST = 16'h01ff;
  localparam logic [ADDR_W-1:0] BANK1_FIRST = 16'h0200;
  localparam logic [ADDR_W-1:0] BANK1_LAST = 16'h02ff;

  // areas inside one bank
  localparam logic [LOCAL_W-1:0] CORE_LAST = 9'h0ff;
  localparam logic [LOCAL_W-1:0] STS_FIRST = 9'h100;
  localparam logic [LOCAL_W-1:0] STS_LAST = 9'h11f;
  localparam logic [LOCAL_W-1:0] TX_FIRST = 9'h120;
  localparam logic [LOCAL_W-1:0] TX_LAST = 9'h13f;
  localparam logic [LOCAL_W-1:0] RX_FIRST = 9'h140;
  localparam logic [LOCAL_W-1:0] RX_LAST = 9'h17f;

  // core configuration registers, 8 bytes apart
  localparam logic [LOCAL_W-1:0] IP_RESET_CTRL = 9'h000;
  localparam logic [LOCAL_W-1:0] IP_COMMAND = 9'h008;
  localparam logic [LOCAL_W-1:0] SRC_MAC_LOW = 9'h010;
  localparam logic [LOCAL_W-1:0] SRC_MAC_HIGH = 9'h018;
  localparam logic [LOCAL_W-1:0] DEST_IP_ADDR = 9'h020;
  localparam logic [LOCAL_W-1:0] SRC_IP_ADDR = 9'h028;
  localparam logic [LOCAL_W-1:0] DEST_PORT_NUM = 9'h030;
  localparam logic [LOCAL_W-1:0] SRC_PORT_NUM = 9'h038;
  localparam logic [LOCAL_W-1:0] TX_DATA_LENGTH = 9'h040;
  localparam logic [LOCAL_W-1:0] TIMEOUT_VALUE = 9'h048;
  localparam logic [LOCAL_W-1:0] PACKET_LENGTH = 9'h050;
  localparam logic [LOCAL_W-1:0] PUSH_CONTROL = 9'h058;
  localparam logic [LOCAL_W-1:0] RECV_CREDIT_THRESHOLD = 9'h060;
  localparam logic [LOCAL_W-1:0] EXTENDED_LENGTH = 9'h068;
  localparam logic [LOCAL_W-1:0] SERVER_MODE = 9'h070;
  localparam logic [LOCAL_W-1:0] IP_REVISION_INFO = 9'h078;
  localparam logic [LOCAL_W-1:0] DEST_MAC_LOW = 9'h080;
  localparam logic [LOCAL_W-1:0] DEST_MAC_HIGH = 9'h088;
  localparam int CORE_REGS = 18;
  localparam int IDX_LSB = 3;

  // status area registers and their fields
  localparam logic [LOCAL_W-1:0] CORE_LINK_STATUS = 9'h100;
  localparam logic [LOCAL_W-1:0] CORE_EVENT_FLAGS = 9'h108;
  localparam int LINK_BIT = 0;
  localparam int CONN_CHG_BIT = 0;
  localparam int TIMER_BIT = 8;

  typedef enum logic [2:0] {
    AREA_CORE, AREA_STATUS, AREA_TX, AREA_RX, AREA_NONE
  } orb_area_type;

  // one write towards an offload core
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] data;
  } orb_core_wr_type;

  // one-hot bank select from the host address
  function automatic logic [BANKS-1:0] bank_sel(
    input logic [ADDR_W-1:0] a);
    logic [BANKS-1:0] s;
    s = 2'b00;
    if (a <= BANK0_LAST) begin
      s = 2'b01;
    end else if (a >= BANK1_FIRST && a <= BANK1_LAST) begin
      s = 2'b10;
    end
    return s;
  endfunction

  // area of a bank-local offset
  function automatic orb_area_type area_of(input logic [LOCAL_W-1:0] o);
    orb_area_type r;
    r = AREA_NONE;
    if (o <= CORE_LAST) begin
      r = AREA_CORE;
    end else if (o >= STS_FIRST && o <= STS_LAST) begin
      r = AREA_STATUS;
    end else if (o >= TX_FIRST && o <= TX_LAST) begin
      r = AREA_TX;
    end else if (o >= RX_FIRST && o <= RX_LAST) begin
      r = AREA_RX;
    end
    return r;
  endfunction

  // offset names an existing core register
  function automatic logic core_hit(input logic [LOCAL_W-1:0] o);
    return area_of(o) == AREA_CORE && o[IDX_LSB-1:0] == 3'h0 &&
           int'(o[IDX_LSB+IDX_W-1:IDX_LSB]) < CORE_REGS;
  endfunction

endpackage

/* File: hdl/orb_register_router.sv */
// host configuration router with two offload register banks
// assumes core status inputs and core read data share SYS_CLK
`timescale 1ns/1ps

// Overview of operation
// RL1: upper address bits pick which of the two banks serves an access
// RL2: 0x0000-0x01FF reach bank 0, 0x0200-0x02FF reach bank 1
// RL3: writes forward only the low 32 data bits, bits 63:32 dropped
// RL4: reads return the bank word low, zeros in bits 63:32
// RL5: bank 0 areas: core config, core status, tx adapter, rx adapter; bank 1 area: core config only
// RL6: upper offset bits pick the area, lower bits the register
// RL7: read data and valid arrive exactly two cycles after the request
// RL8: read value chosen by a two-level mux with a registered middle
// RL9: offsets 0x00-0x88 step 8 pass through to core registers
// RL10: offset 0x100 bit 0 shows the link established level
// RL11: flag bit 0 at 0x108 sets when the link level changes
// RL12: host writes 1 to bit 0 to clear the link change flag
// RL13: flag bit 8 latches the core timer event until written with 1
// RL14: unmapped offsets read zero and ignore writes
module orb_register_router #(
  parameter int CORE_REG_COUNT = orb_pkg::CORE_REGS
) (
  // clock and reset
  input logic SYS_CLK,
  input logic RST_N,
  // host write port
  input logic CFG_WR_EN,
  input logic [orb_pkg::ADDR_W-1:0] CFG_WR_ADDR,
  input logic [orb_pkg::HOST_W-1:0] CFG_WR_DATA,
  // host read port
  input logic CFG_RD_REQ,
  input logic [orb_pkg::ADDR_W-1:0] CFG_RD_ADDR,
  output logic [orb_pkg::HOST_W-1:0] CFG_RD_DATA,
  output logic CFG_RD_VALID,
  // offload core configuration registers
  output logic [orb_pkg::BANKS-1:0] CORE_WR_EN,
  output orb_pkg::orb_core_wr_type CORE_WR,
  output logic [orb_pkg::IDX_W-1:0] CORE_RD_IDX,
  input logic [orb_pkg::REG_W-1:0] CORE_RD_DATA_0,
  input logic [orb_pkg::REG_W-1:0] CORE_RD_DATA_1,
  // offload core status
  input logic [orb_pkg::BANKS-1:0] LINK_ESTABLISHED,
  input logic [orb_pkg::BANKS-1:0] CORE_TIMER_EVENT
);

  if (CORE_REG_COUNT < 1 || CORE_REG_COUNT > orb_pkg::CORE_REGS) begin
    $error("core register count out of range");
  end

  localparam int B = orb_pkg::BANKS;
  localparam int W = orb_pkg::REG_W;
  localparam int IL = orb_pkg::IDX_LSB;
  localparam int IW = orb_pkg::IDX_W;

  logic [B-1:0] wr_bank;
  logic [orb_pkg::LOCAL_W-1:0] wr_ofs;
  logic [B-1:0] clr_conn;
  logic [B-1:0] clr_tmr;
  logic [B-1:0] core_wr_en_r, core_wr_en_nxt;
  orb_pkg::orb_core_wr_type core_wr_r, core_wr_nxt;
  logic [B-1:0] link_r, link_nxt;
  logic [B-1:0] conn_chg_r, conn_chg_nxt;
  logic [B-1:0] timer_r, timer_nxt;

  // write decode: bank by upper host bits, area and register by offset
  always_comb begin
    wr_bank = orb_pkg::bank_sel(CFG_WR_ADDR); // RL1 RL2
    wr_ofs = CFG_WR_ADDR[orb_pkg::LOCAL_W-1:0]; // RL6
    core_wr_en_nxt = '0;
    core_wr_nxt = core_wr_r;
    clr_conn = '0;
    clr_tmr = '0;
    if (CFG_WR_EN) begin
      if (orb_pkg::core_hit(wr_ofs) &&
          int'(wr_ofs[IL +: IW]) < CORE_REG_COUNT) begin
        core_wr_en_nxt = wr_bank; // RL9
        core_wr_nxt.idx = wr_ofs[IL +: IW];
        core_wr_nxt.data = CFG_WR_DATA[W-1:0]; // RL3
      end
      if (wr_ofs == orb_pkg::CORE_EVENT_FLAGS) begin
        clr_conn = wr_bank & {B{CFG_WR_DATA[orb_pkg::CONN_CHG_BIT]}};
        clr_tmr = wr_bank & {B{CFG_WR_DATA[orb_pkg::TIMER_BIT]}};
      end
    end
  end

  // event flags: a set in the clearing cycle wins over the clear
  always_comb begin
    link_nxt = LINK_ESTABLISHED;
    conn_chg_nxt = (conn_chg_r & ~clr_conn) | // RL12
                   (LINK_ESTABLISHED ^ link_r); // RL11
    timer_nxt = (timer_r & ~clr_tmr) | CORE_TIMER_EVENT; // RL13
  end

  // write side and flag registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      core_wr_en_r <= '0;
      core_wr_r <= '0;
      link_r <= '0;
      conn_chg_r <= '0;
      timer_r <= '0;
    end else begin
      core_wr_en_r <= core_wr_en_nxt;
      core_wr_r <= core_wr_nxt;
      link_r <= link_nxt;
      conn_chg_r <= conn_chg_nxt;
      timer_r <= timer_nxt;
    end
  end

  logic [B-1:0] rd_bank;
  logic [orb_pkg::LOCAL_W-1:0] rd_ofs;
  logic rd_v1_r, rd_v1_nxt;
  logic rd_b1_r, rd_b1_nxt;
  logic rd_core1_r, rd_core1_nxt;
  logic [W-1:0] sts1_r, sts1_nxt;
  logic [orb_pkg::IDX_W-1:0] rd_idx_r, rd_idx_nxt;
  logic rd_v2_r, rd_v2_nxt;
  logic [orb_pkg::HOST_W-1:0] rd_data_r, rd_data_nxt;
  logic [W-1:0] rd_word;

  // read stage one: decode and first mux level over status sources
  always_comb begin
    rd_bank = orb_pkg::bank_sel(CFG_RD_ADDR); // RL1 RL2
    rd_ofs = CFG_RD_ADDR[orb_pkg::LOCAL_W-1:0]; // RL6
    rd_v1_nxt = CFG_RD_REQ; // RL7
    rd_b1_nxt = rd_bank[1];
    rd_idx_nxt = rd_idx_r;
    rd_core1_nxt = 1'b0;
    sts1_nxt = '0; // RL14
    if (CFG_RD_REQ && rd_bank != '0) begin
      case (orb_pkg::area_of(rd_ofs)) // RL5
        orb_pkg::AREA_CORE: begin
          if (orb_pkg::core_hit(rd_ofs) &&
              int'(rd_ofs[IL +: IW]) < CORE_REG_COUNT) begin
            rd_core1_nxt = 1'b1; // RL9
            rd_idx_nxt = rd_ofs[IL +: IW];
          end
        end
        orb_pkg::AREA_STATUS: begin
          if (rd_ofs == orb_pkg::CORE_LINK_STATUS) begin
            sts1_nxt[orb_pkg::LINK_BIT] = |(link_r & rd_bank); // RL10
          end else if (rd_ofs == orb_pkg::CORE_EVENT_FLAGS) begin
            sts1_nxt[orb_pkg::CONN_CHG_BIT] = |(conn_chg_r & rd_bank);
            sts1_nxt[orb_pkg::TIMER_BIT] = |(timer_r & rd_bank);
          end
        end
        default: begin
          sts1_nxt = '0; // adapter areas live outside this block
        end
      endcase
    end
  end

  // read stage two: final mux and zero padding of the upper word
  always_comb begin
    rd_word = sts1_r; // RL8
    if (rd_core1_r) begin
      rd_word = rd_b1_r ? CORE_RD_DATA_1 : CORE_RD_DATA_0;
    end
    rd_v2_nxt = rd_v1_r; // RL7
    rd_data_nxt = rd_v1_r ? {{(orb_pkg::HOST_W-W){1'b0}}, rd_word} : '0; // RL4
  end

  // read pipeline registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rd_v1_r <= 1'b0;
      rd_b1_r <= 1'b0;
      rd_core1_r <= 1'b0;
      sts1_r <= '0;
      rd_idx_r <= '0;
      rd_v2_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_v1_r <= rd_v1_nxt;
      rd_b1_r <= rd_b1_nxt;
      rd_core1_r <= rd_core1_nxt;
      sts1_r <= sts1_nxt; // RL8
      rd_idx_r <= rd_idx_nxt;
      rd_v2_r <= rd_v2_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // outputs straight from flip-flops
  assign CFG_RD_DATA = rd_data_r;
  assign CFG_RD_VALID = rd_v2_r;
  assign CORE_WR_EN = core_wr_en_r;
  assign CORE_WR = core_wr_r;
  assign CORE_RD_IDX = rd_idx_r;

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  rd_latency_a: assert property (CFG_RD_REQ |-> ##2 CFG_RD_VALID) // RL7
    else $error("read valid not two cycles after request");
  rd_cause_a: assert property (CFG_RD_VALID |-> $past(CFG_RD_REQ, 2)) // RL7
    else $error("read valid without a request");
  upper_zero_a: assert property (CFG_RD_VALID |-> // RL4
    CFG_RD_DATA[63:32] == 32'h0)
    else $error("upper read word not zero");
  wr_low_a: assert property (CFG_WR_EN && // RL3
    CFG_WR_ADDR == 16'h0008 |=> CORE_WR_EN == 2'b01 &&
    CORE_WR.idx == 5'h01 && CORE_WR.data == $past(CFG_WR_DATA[31:0]))
    else $error("core write not the low data word");
  bank1_route_a: assert property (CFG_WR_EN && // RL2
    CFG_WR_ADDR == 16'h0288 |=> CORE_WR_EN == 2'b10 &&
    CORE_WR.idx == 5'h11)
    else $error("bank one write misrouted");
  conn_set_a: assert property ($changed(link_r[0]) |-> // RL11
    conn_chg_r[0])
    else $error("link change not flagged");
  conn_clear_a: assert property (conn_chg_r[0] && clr_conn[0] && // RL12
    LINK_ESTABLISHED[0] == link_r[0] |=> !conn_chg_r[0])
    else $error("link change flag not cleared");
  timer_hold_a: assert property (timer_r[0] && !clr_tmr[0] |=> // RL13
    timer_r[0])
    else $error("timer flag lost");
  link_read_a: assert property (CFG_RD_REQ && // RL10
    CFG_RD_ADDR == 16'h0100 |-> ##2 CFG_RD_DATA[0] == $past(link_r[0], 2))
    else $error("link status read wrong");
  unmapped_rd_a: assert property (CFG_RD_REQ && // RL14
    (CFG_RD_ADDR == 16'h0120 || CFG_RD_ADDR == 16'h0300) |->
    ##2 CFG_RD_DATA == 64'h0)
    else $error("unmapped read not zero");

  // never more than one bank written per cycle
  wr_onehot_a: assert property ($onehot0(CORE_WR_EN)) // RL1
    else $error("core write strobe on both banks");

  // first register of the first bank
  bank0_route_a: assert property (CFG_WR_EN && // RL2
    CFG_WR_ADDR == 16'h0000 |=> CORE_WR_EN == 2'b01 && CORE_WR.idx == 5'h00)
    else $error("bank zero write misrouted");

  // addresses above the second bank reach no core
  high_wr_a: assert property (CFG_WR_EN && // RL2
    CFG_WR_ADDR >= 16'h0300 |=> CORE_WR_EN == 2'b00)
    else $error("write above bank windows reached a core");

  // offsets off the 8-byte grid reach no core
  misaligned_wr_a: assert property (CFG_WR_EN && // RL14
    CFG_WR_ADDR[2:0] != 3'h0 |=> CORE_WR_EN == 2'b00)
    else $error("misaligned write reached a core");

  // core write strobe only follows a host write
  wr_pulse_a: assert property (!CFG_WR_EN |=> // RL9
    CORE_WR_EN == 2'b00)
    else $error("core write without host write");

  // read data is zero outside the valid cycle
  rd_idle_zero_a: assert property (!CFG_RD_VALID |-> // RL4
    CFG_RD_DATA == 64'h0)
    else $error("read data not zero while idle");

  // no valid without a request two cycles earlier
  idle_no_valid_a: assert property (!CFG_RD_REQ |-> // RL7
    ##2 !CFG_RD_VALID)
    else $error("read valid without request");

  // core read index follows a core register read
  core_idx_a: assert property (CFG_RD_REQ && // RL6
    CFG_RD_ADDR == 16'h0008 |=> CORE_RD_IDX == 5'h01)
    else $error("core read index wrong");

  // core read index holds between reads
  rd_idx_hold_a: assert property (!CFG_RD_REQ |=> // RL9
    $stable(CORE_RD_IDX))
    else $error("core read index moved without request");

  // bank zero core word reaches the host
  core_rd_data_a: assert property (CFG_RD_REQ && // RL9
    CFG_RD_ADDR == 16'h0008 |->
    ##2 CFG_RD_DATA[31:0] == $past(CORE_RD_DATA_0))
    else $error("bank zero core read data wrong");

  // bank one core word reaches the host
  bank1_read_a: assert property (CFG_RD_REQ && // RL2
    CFG_RD_ADDR == 16'h0288 |->
    ##2 CFG_RD_DATA[31:0] == $past(CORE_RD_DATA_1))
    else $error("bank one core read data wrong");

  // receive adapter area reads zero here
  rx_area_a: assert property (CFG_RD_REQ && // RL5
    CFG_RD_ADDR == 16'h0140 |-> ##2 CFG_RD_DATA == 64'h0)
    else $error("adapter area read not zero");

  // event flag register shows both flags
  flag_read_a: assert property (CFG_RD_REQ && // RL11
    CFG_RD_ADDR == 16'h0108 |-> ##2 CFG_RD_DATA[8] == $past(timer_r[0], 2) &&
    CFG_RD_DATA[0] == $past(conn_chg_r[0], 2))
    else $error("event flag read wrong");

  // link change flag stays until cleared
  conn_hold_a: assert property (conn_chg_r[0] && !clr_conn[0] |=> // RL11
    conn_chg_r[0])
    else $error("link change flag lost");

  // timer event sets its flag
  timer_set_a: assert property (CORE_TIMER_EVENT[0] |=> // RL13
    timer_r[0])
    else $error("timer event not latched");

  // writing one to bit 8 clears the timer flag
  timer_clear_a: assert property (timer_r[0] && clr_tmr[0] && // RL13
    !CORE_TIMER_EVENT[0] |=> !timer_r[0])
    else $error("timer flag not cleared");

  back_to_back_c: cover property (CFG_RD_REQ ##1 CFG_RD_REQ);
  flag_read_c: cover property (CFG_RD_REQ &&
    CFG_RD_ADDR == 16'h0108 ##2 CFG_RD_DATA[8]);
  bank1_write_c: cover property (CORE_WR_EN[1]);
  set_beats_clear_c: cover property (clr_conn[0] &&
    LINK_ESTABLISHED[0] != link_r[0]);
  timer_clear_c: cover property (timer_r[0] ##1 !timer_r[0]);

endmodule

/* File: sim/orb_core_model.sv */
// behavioural offload core configuration registers, one set per bank
// assumes reads are combinational on the shared index, writes on SYS_CLK
`timescale 1ns/1ps
module orb_core_model (
  // clock
  input wire logic sys_clk,
  // core register port
  input wire logic [orb_pkg::BANKS-1:0] wr_en,
  input wire orb_pkg::orb_core_wr_type wr,
  input wire logic [orb_pkg::IDX_W-1:0] rd_idx,
  output logic [orb_pkg::REG_W-1:0] rd_data_0,
  output logic [orb_pkg::REG_W-1:0] rd_data_1
);
  logic [orb_pkg::REG_W-1:0] regs_r [2][18];
  logic [orb_pkg::REG_W-1:0] junk;
  // store each bank's write, one register per index
  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < 2; b++) begin
      if (wr_en[b] && wr.idx < 5'h12) begin
        regs_r[b][wr.idx] <= wr.data;
      end
    end
  end
  // indices without a register give a pattern that toggles on each clock edge
  assign junk = {16{sys_clk, ~sys_clk}};
  assign rd_data_0 = (rd_idx < 5'h12) ? regs_r[0][rd_idx] : junk;
  assign rd_data_1 = (rd_idx < 5'h12) ? regs_r[1][rd_idx] : junk;
endmodule

/* File: sim/orb_register_router_test.sv */
// self-checking bench of the two-bank register router
// assumes the core model above answers the core register port
`timescale 1ns/1ps
module orb_register_router_test;
  logic clk, rst_n, wr_en, rd_req, rd_vld;
  logic [15:0] wr_addr, rd_addr;
  logic [63:0] wr_data, rd_data;
  logic [1:0] core_en, link, timer;
  orb_pkg::orb_core_wr_type core_wr;
  logic [4:0] rd_idx;
  logic [31:0] cd0, cd1;
  int num_errors, tests_run;
  logic [15:0] bad [7] = '{16'h0004, 16'h0098, 16'h0120, 16'h0140,
                           16'h0180, 16'h0300, 16'h0290};

  orb_register_router dut_u (.SYS_CLK(clk), .RST_N(rst_n),
    .CFG_WR_EN(wr_en), .CFG_WR_ADDR(wr_addr), .CFG_WR_DATA(wr_data),
    .CFG_RD_REQ(rd_req), .CFG_RD_ADDR(rd_addr), .CFG_RD_DATA(rd_data),
    .CFG_RD_VALID(rd_vld), .CORE_WR_EN(core_en), .CORE_WR(core_wr),
    .CORE_RD_IDX(rd_idx), .CORE_RD_DATA_0(cd0), .CORE_RD_DATA_1(cd1),
    .LINK_ESTABLISHED(link), .CORE_TIMER_EVENT(timer));
  orb_core_model core_u (.sys_clk(clk), .wr_en(core_en), .wr(core_wr),
    .rd_idx(rd_idx), .rd_data_0(cd0), .rd_data_1(cd1));

  // compare and count
  task automatic chk(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ends the run with the verdict
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one host write, then the core strobe one cycle later
  task automatic wr(input logic [15:0] a, input logic [63:0] d,
                    input logic [1:0] en);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    chk("core_wr_en", 64'(core_en), 64'(en));
    if (en != 2'b00) begin
      chk("core_wr_data", 64'(core_wr.data), 64'(d[31:0]));
      chk("core_wr_idx", 64'(core_wr.idx), 64'(a[7:3]));
    end
  endtask

  // one host read, valid and data exactly two cycles after
  task automatic rd(input logic [15:0] a, input logic [63:0] e);
    @(negedge clk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_req = 1'b0;
    chk("rd_valid early", 64'(rd_vld), 64'h0);
    @(negedge clk);
    chk("rd_valid", 64'(rd_vld), 64'h1);
    chk("rd_data", rd_data, e);
    @(negedge clk);
    chk("rd_valid after", 64'(rd_vld), 64'h0);
    chk("rd_data after", rd_data, 64'h0);
  endtask

  // every core register of both banks, upper word filled with ones
  task automatic core_regs();
    for (int i = 0; i < 18; i++) begin
      wr(16'(8 * i), {32'hffffffff, 32'ha5000000 | i}, 2'b01);
      wr(16'(8 * i + 512), {32'hffffffff, 32'hc3000000 | i}, 2'b10);
    end
    for (int i = 0; i < 18; i++) begin
      rd(16'(8 * i), {32'h0, 32'ha5000000 | i});
      chk("core_rd_idx", 64'(rd_idx), 64'(i));
      rd(16'(8 * i + 512), {32'h0, 32'hc3000000 | i});
      chk("core_rd_idx", 64'(rd_idx), 64'(i));
    end
  endtask

  // unmapped places ignore writes and read zero
  task automatic unmapped();
    for (int i = 0; i < 7; i++) begin
      wr(bad[i], 64'h0000000012345678, 2'b00);
      rd(bad[i], 64'h0);
    end
    rd(16'h0000, 64'h00000000a5000000);
  endtask

  // link level, its change flag and the clear by writing one
  task automatic link_flag();
    link = 2'b10;
    rd(16'h0108, 64'h0);
    link = 2'b01;
    rd(16'h0100, 64'h1);
    rd(16'h0108, 64'h1);
    wr(16'h0108, 64'h1, 2'b00);
    rd(16'h0108, 64'h0);
    link = 2'b00;
    rd(16'h0100, 64'h0);
    rd(16'h0108, 64'h1);
    wr(16'h0108, 64'h1, 2'b00);
    rd(16'h0108, 64'h0);
  endtask

  // change in the clearing cycle sets the flag; two reads back to back
  task automatic race_b2b();
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = 16'h0108;
    wr_data = 64'h1;
    link = 2'b01;
    @(negedge clk);
    wr_en = 1'b0;
    rd_req = 1'b1;
    rd_addr = 16'h0100;
    @(negedge clk);
    rd_addr = 16'h0108;
    @(negedge clk);
    rd_req = 1'b0;
    chk("b2b valid first", 64'(rd_vld), 64'h1);
    chk("b2b link", rd_data, 64'h1);
    @(negedge clk);
    chk("b2b valid second", 64'(rd_vld), 64'h1);
    chk("set beats clear", rd_data, 64'h1);
    wr(16'h0108, 64'h1, 2'b00);
    rd(16'h0108, 64'h0);
  endtask

  // timer event latched until bit 8 is written with one
  task automatic timer_flag();
    @(negedge clk);
    timer = 2'b11;
    @(negedge clk);
    timer = 2'b00;
    rd(16'h0108, 64'h100);
    wr(16'h0108, 64'h1, 2'b00);
    rd(16'h0108, 64'h100);
    wr(16'h0108, 64'h100, 2'b00);
    rd(16'h0108, 64'h0);
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard
  initial begin
    #400000;
    num_errors++;
    results();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_req = 1'b0;
    wr_addr = 16'h0;
    rd_addr = 16'h0;
    wr_data = 64'h0;
    link = 2'b00;
    timer = 2'b00;
    num_errors = 0;
    tests_run = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    core_regs();
    unmapped();
    link_flag();
    race_b2b();
    timer_flag();
    results();
  end
endmodule
